//--- logic/ptg_defs.svh
// Constants of the sector pattern tester: offsets, fields, reset values.
`ifndef PTG_DEFS_SVH
`define PTG_DEFS_SVH

// ---------------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ---------------------------------------------------------------------
`define PTG_OFF_CTRL 8'h00
`define PTG_OFF_PATSEL 8'h04
`define PTG_OFF_END 8'h08
`define PTG_OFF_ADDR_LO 8'h0C
`define PTG_OFF_ADDR_HI 8'h10
`define PTG_OFF_STATUS 8'h14
`define PTG_OFF_COUNT 8'h18

// ---------------------------------------------------------------------
// Field positions and widths
// ---------------------------------------------------------------------
`define PTG_CTRL_WR_BIT 0
`define PTG_CTRL_RD_BIT 1
`define PTG_ST_WR_BIT 0
`define PTG_ST_RD_BIT 1
`define PTG_ST_FAIL_BIT 2
`define PTG_REG_AW 8
`define PTG_REG_DW 32
`define PTG_SEL_W 3
`define PTG_ADDR_W 48
`define PTG_ADDR_HI_W 16
`define PTG_CNT_W 32
`define PTG_WORD_W 256
`define PTG_LANES 8
`define PTG_SECT_FIRST 4'h0
`define PTG_SECT_LAST 4'hF

// ---------------------------------------------------------------------
// Reset values and fixed patterns
// ---------------------------------------------------------------------
`define PTG_RST_PATSEL 3'h0
`define PTG_RST_END 32'h00000000
`define PTG_RST_ADDR 48'h000000000000
`define PTG_RST_CNT 32'h00000000
`define PTG_RST_WORD 256'h0
`define PTG_RST_LFSR 32'h00000000
`define PTG_HDR_PAD 16'h0000
`define PTG_LFSR_TAPS 32'h80200003

`endif

//--- logic/ptg_pkg.sv
// Types shared by the sector pattern tester modules.
`include "ptg_defs.svh"

package ptg_pkg;

  // Operation state; WRITE doubles as the write-transfer-active flag
  typedef enum logic [1:0] {
    PTG_IDLE = 2'b00,
    PTG_WRITE = 2'b01,
    PTG_READ = 2'b10
  } ptg_state_t;

  // Fill pattern encodings of the select field
  typedef enum logic [2:0] {
    PTG_PAT_INC = 3'b000,
    PTG_PAT_DEC = 3'b001,
    PTG_PAT_ZERO = 3'b010,
    PTG_PAT_ONE = 3'b011,
    PTG_PAT_LFSR = 3'b100
  } ptg_pattern_t;

  // One register access from software, strobes are one cycle long
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`PTG_REG_AW-1:0] addr;
    logic [`PTG_REG_DW-1:0] wdata;
  } ptg_reg_req_t;

endpackage

//--- logic/ptg_lfsr_ahead.sv
// Look-ahead 32-bit LFSR giving four successive states in one cycle.
`include "ptg_defs.svh"

module ptg_lfsr_ahead
  import ptg_pkg::*;
(
  // Current state
  input wire logic [31:0] state_i,
  // Four successive values, the current one in the low lane
  output logic [127:0] lanes_o,
  output logic [31:0] next_o
);

  // Chain of single steps; synthesis flattens it into one XOR network
  logic [31:0] chain [0:4];

  assign chain[0] = state_i;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_step
      assign lanes_o[g*32 +: 32] = chain[g];
      assign chain[g+1] = {chain[g][30:0], ^(chain[g] & `PTG_LFSR_TAPS)};
    end
  endgenerate

  // State for the next 256-bit word
  assign next_o = chain[4];

endmodule

//--- logic/ptg_pattern_tester.sv
// Sector pattern generator and checker with its parameter registers.
`include "ptg_defs.svh"

module ptg_pattern_tester
  import ptg_pkg::*;
(
  // Clock, reset and freeze
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // Register port
  input wire ptg_reg_req_t reg_req_i,
  output logic [`PTG_REG_DW-1:0] reg_rdata_o,
  // Transmit buffer
  input wire logic tx_buffer_almost_full_i,
  output logic tx_buffer_write_strobe_o,
  output logic [`PTG_WORD_W-1:0] tx_buffer_word_o,
  // Receive buffer, data valid the cycle after a pop
  input wire logic rx_buffer_empty_i,
  input wire logic [`PTG_WORD_W-1:0] rx_buffer_word_i,
  output logic rx_buffer_pop_o,
  // Status
  output logic write_transfer_active_o,
  output logic verify_fail_o
);

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  ptg_state_t state;
  logic [`PTG_SEL_W-1:0] pattern_select;
  logic [`PTG_CNT_W-1:0] transfer_end_count, word_counter;
  logic [`PTG_ADDR_W-1:0] start_address, sector_address_reg;
  logic [`PTG_WORD_W-1:0] generated_word, pattern_word, next_generated_word;
  logic write_start_pulse, read_start_pulse, start_write, start_read;
  logic tx_buffer_write_strobe, write_transfer_active, read_active, write_fire;
  logic rx_buffer_pop, step_en, at_end, sector_first;
  logic compare_pending, mismatch, verify_fail;
  logic [31:0] lfsr_state0, lfsr_state1, lfsr_cur0, lfsr_cur1, lfsr_next0, lfsr_next1;
  logic [31:0] sector_lba_value, sector_lba_inverted;
  logic [127:0] lfsr_lane_0, lfsr_lane_1;

  // ---------------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------------
  // Start bits are self-clearing one-cycle pulses
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      write_start_pulse <= 1'b0;
      read_start_pulse <= 1'b0;
    end else if (ce_i) begin
      write_start_pulse <= reg_req_i.wr && reg_req_i.addr == `PTG_OFF_CTRL
                           && reg_req_i.wdata[`PTG_CTRL_WR_BIT];
      read_start_pulse <= reg_req_i.wr && reg_req_i.addr == `PTG_OFF_CTRL
                          && reg_req_i.wdata[`PTG_CTRL_RD_BIT];
    end
  end

  // Parameters; the select is used live, so change it only while idle
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      pattern_select <= `PTG_RST_PATSEL;
      transfer_end_count <= `PTG_RST_END;
      start_address <= `PTG_RST_ADDR;
    end else if (ce_i && reg_req_i.wr) begin
      case (reg_req_i.addr)
        `PTG_OFF_PATSEL: pattern_select <= reg_req_i.wdata[`PTG_SEL_W-1:0];
        `PTG_OFF_END: transfer_end_count <= reg_req_i.wdata;
        `PTG_OFF_ADDR_LO: start_address[31:0] <= reg_req_i.wdata;
        `PTG_OFF_ADDR_HI: start_address[`PTG_ADDR_W-1:32] <=
            reg_req_i.wdata[`PTG_ADDR_HI_W-1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------------
  // Data stand only in the cycle after the read strobe; unmapped reads zero
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= '0;
    end else if (ce_i) begin
      reg_rdata_o <= '0;
      if (reg_req_i.rd) begin
        case (reg_req_i.addr)
          `PTG_OFF_PATSEL: reg_rdata_o <= {29'h0, pattern_select};
          `PTG_OFF_END: reg_rdata_o <= transfer_end_count;
          `PTG_OFF_ADDR_LO: reg_rdata_o <= start_address[31:0];
          `PTG_OFF_ADDR_HI: reg_rdata_o <= {16'h0, start_address[`PTG_ADDR_W-1:32]};
          `PTG_OFF_STATUS: reg_rdata_o <= {29'h0, verify_fail, read_active,
                                           write_transfer_active};
          `PTG_OFF_COUNT: reg_rdata_o <= word_counter;
          default: reg_rdata_o <= '0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------
  // Transfer control
  // ---------------------------------------------------------------------
  // Starts are taken only while idle, so a running test is never restarted
  assign start_write = write_start_pulse && state == PTG_IDLE;
  assign start_read = read_start_pulse && !write_start_pulse && state == PTG_IDLE;
  assign write_transfer_active = state == PTG_WRITE;
  assign read_active = state == PTG_READ;
  assign at_end = word_counter == transfer_end_count;
  assign sector_first = word_counter[3:0] == `PTG_SECT_FIRST;
  assign write_fire = write_transfer_active && !tx_buffer_almost_full_i && !at_end;
  assign rx_buffer_pop = read_active && !rx_buffer_empty_i && !at_end;
  assign step_en = write_fire || rx_buffer_pop;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state <= PTG_IDLE;
    end else if (ce_i) begin
      case (state)
        PTG_IDLE: begin
          if (start_write) begin
            state <= PTG_WRITE;
          end else if (start_read) begin
            state <= PTG_READ;
          end
        end
        PTG_WRITE: begin
          if (at_end) begin
            state <= PTG_IDLE;
          end
        end
        PTG_READ: begin
          if (at_end) begin
            state <= PTG_IDLE;
          end
        end
        default: state <= PTG_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      tx_buffer_write_strobe <= 1'b0;
    end else if (ce_i) begin
      tx_buffer_write_strobe <= write_fire;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      word_counter <= `PTG_RST_CNT;
    end else if (ce_i) begin
      if (start_write || start_read) begin
        word_counter <= `PTG_RST_CNT;
      end else if (step_en) begin
        word_counter <= word_counter + 32'h00000001;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      sector_address_reg <= `PTG_RST_ADDR;
    end else if (ce_i) begin
      if (start_write || start_read) begin
        sector_address_reg <= start_address;
      end else if (step_en && word_counter[3:0] == `PTG_SECT_LAST) begin
        sector_address_reg <= sector_address_reg + 48'h000000000001;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Pattern generation
  // ---------------------------------------------------------------------
  // set 0 seed
  assign sector_lba_value = {~sector_address_reg[31:16], sector_address_reg[15:0]};
  assign sector_lba_inverted = {sector_address_reg[31:16], ~sector_address_reg[15:0]};
  // Reseed at each sector; an all-zero seed stays zero for that sector
  assign lfsr_cur0 = sector_first ? sector_lba_value : lfsr_state0;
  assign lfsr_cur1 = sector_first ? sector_lba_inverted : lfsr_state1;

  ptg_lfsr_ahead u_lfsr0 (
    .state_i(lfsr_cur0),
    .lanes_o(lfsr_lane_0),
    .next_o(lfsr_next0)
  );

  ptg_lfsr_ahead u_lfsr1 (
    .state_i(lfsr_cur1),
    .lanes_o(lfsr_lane_1),
    .next_o(lfsr_next1)
  );

  // LFSR states move four steps per accepted word
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      lfsr_state0 <= `PTG_RST_LFSR;
      lfsr_state1 <= `PTG_RST_LFSR;
    end else if (ce_i && step_en) begin
      lfsr_state0 <= lfsr_next0;
      lfsr_state1 <= lfsr_next1;
    end
  end

  genvar lane;
  generate
    for (lane = 0; lane < `PTG_LANES; lane++) begin : g_lane
      logic [31:0] inc_value;
      logic [31:0] lfsr_value;
      logic [31:0] lane_word;
      assign inc_value = {sector_address_reg[24:0], word_counter[3:0], 3'(lane)};
      // even lanes set 0, odd set 1
      assign lfsr_value = (lane % 2 == 0) ? lfsr_lane_0[(lane/2)*32 +: 32]
                                          : lfsr_lane_1[(lane/2)*32 +: 32];
      always_comb begin
        case (pattern_select)
          PTG_PAT_INC: lane_word = inc_value;
          PTG_PAT_DEC: lane_word = ~inc_value;
          PTG_PAT_ZERO: lane_word = 32'h00000000;
          PTG_PAT_ONE: lane_word = 32'hFFFFFFFF;
          PTG_PAT_LFSR: lane_word = lfsr_value;
          default: lane_word = 32'h00000000;
        endcase
      end
      assign pattern_word[lane*32 +: 32] = lane_word;
    end
  endgenerate

  // header in lanes 0 and 1
  assign next_generated_word = sector_first
      ? {pattern_word[`PTG_WORD_W-1:64], `PTG_HDR_PAD, sector_address_reg}
      : pattern_word;

  // 256-bit word register, shared by write data and expected value
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      generated_word <= `PTG_RST_WORD;
    end else if (ce_i && step_en) begin
      generated_word <= next_generated_word;
    end
  end

  // ---------------------------------------------------------------------
  // Verification
  // ---------------------------------------------------------------------
  // Received data arrive one cycle after the pop, in step with the expected word
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      compare_pending <= 1'b0;
    end else if (ce_i) begin
      compare_pending <= rx_buffer_pop;
    end
  end

  assign mismatch = compare_pending && rx_buffer_word_i != generated_word;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      verify_fail <= 1'b0;
    end else if (ce_i) begin
      if (mismatch) begin
        verify_fail <= 1'b1;
      end else if (start_write || start_read) begin
        verify_fail <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign tx_buffer_write_strobe_o = tx_buffer_write_strobe;
  assign tx_buffer_word_o = generated_word;
  assign rx_buffer_pop_o = rx_buffer_pop;
  assign write_transfer_active_o = write_transfer_active;
  assign verify_fail_o = verify_fail;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  start_sets_active_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ce_i && write_start_pulse && state == PTG_IDLE |=> write_transfer_active [*1])
    else $error("write start did not set active");

  strobe_gated_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ce_i && write_transfer_active && tx_buffer_almost_full_i |=> !tx_buffer_write_strobe)
    else $error("strobe while almost full");

  strobe_runs_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ce_i && write_transfer_active && !tx_buffer_almost_full_i && !at_end
    |=> tx_buffer_write_strobe && word_counter == $past(word_counter) + 32'h00000001)
    else $error("write strobe missing");

  end_stops_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ce_i && write_transfer_active && at_end |=> !write_transfer_active
    && !tx_buffer_write_strobe)
    else $error("transfer did not stop at end count");

  pop_inverse_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    read_active && !at_end |-> rx_buffer_pop == !rx_buffer_empty_i)
    else $error("pop is not inverse of empty");

  pop_counts_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ce_i && rx_buffer_pop |=> word_counter == $past(word_counter) + 32'h00000001)
    else $error("pop did not advance counter");

  header_first_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ce_i && step_en && sector_first
    |=> generated_word[63:0] == {`PTG_HDR_PAD, $past(sector_address_reg)})
    else $error("sector header missing");

  addr_step_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ce_i && step_en && word_counter[3:0] == `PTG_SECT_LAST && !start_write
    |=> sector_address_reg == $past(sector_address_reg) + 48'h000000000001)
    else $error("sector address did not step");

  mismatch_flag_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ce_i && compare_pending && rx_buffer_word_i != generated_word |=> verify_fail)
    else $error("mismatch not flagged");

  fail_sticky_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    verify_fail && !(ce_i && (start_write || start_read)) |=> verify_fail)
    else $error("fail flag dropped");

  reset_clear_a: assert property (@(posedge mclk_i)
    !reset_n_i |=> !tx_buffer_write_strobe && !rx_buffer_pop && !verify_fail
    && word_counter == `PTG_RST_CNT)
    else $error("reset did not clear state");

endmodule

//--- bench/ptg_fifo_model.sv
// Behavioural transmit and receive buffers that loop written words back for reading.
`include "ptg_defs.svh"

module ptg_fifo_model
  import ptg_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Test controls
  input wire logic tx_stall_i,
  input wire logic rx_hold_i,
  input wire logic corrupt_i,
  // Transmit buffer side
  input wire logic wr_strobe_i,
  input wire logic [`PTG_WORD_W-1:0] wr_word_i,
  output logic almost_full_o,
  // Receive buffer side
  input wire logic pop_i,
  output logic empty_o,
  output logic [`PTG_WORD_W-1:0] rd_word_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [`PTG_WORD_W-1:0] mem [64];
  logic [5:0] wp;
  logic [5:0] rp;
  logic [5:0] fill;

  // ---------------------------------------------------------------
  // Flags
  // ---------------------------------------------------------------
  // Afull leaves headroom for the word already in flight when it rises
  assign fill = wp - rp;
  assign almost_full_o = tx_stall_i | (fill >= 6'h38);
  assign empty_o = rx_hold_i | (fill == 6'h00);

  // Store every strobed word
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      wp <= 6'h00;
    end else if (wr_strobe_i) begin
      mem[wp] <= wr_word_i;
      wp <= wp + 6'h01;
    end
  end

  // Data is valid only in the cycle after a pop; otherwise junk that toggles
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rp <= 6'h00;
      rd_word_o <= 256'h0;
    end else if (pop_i) begin
      rd_word_o <= mem[rp] ^ {255'h0, corrupt_i};
      rp <= rp + 6'h01;
    end else begin
      rd_word_o <= ~rd_word_o;
    end
  end
endmodule

//--- bench/ptg_pattern_tester_tb_top.sv
// Self-checking bench for the sector pattern tester with a loopback buffer model.
`include "ptg_defs.svh"

module ptg_pattern_tester_tb_top
  import ptg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk = 1'b0;
  logic reset_n;
  logic ce;
  ptg_reg_req_t req;
  logic [31:0] rdata;
  logic afull, strobe, empty, pop, active, fail;
  logic [255:0] txw, rxw;
  logic stall = 1'b0;
  logic hold = 1'b0;
  logic corrupt, stall_en, af_d1, af_d2;
  logic [2:0] sel;
  logic [47:0] base;
  int err_total = 0;
  int total_checks = 0;
  int nwr = 0;
  int cyc = 0;

  always #10 mclk = ~mclk;

  ptg_pattern_tester u_ptg_pattern_tester (.mclk_i(mclk), .reset_n_i(reset_n), .ce_i(ce),
    .reg_req_i(req), .reg_rdata_o(rdata), .tx_buffer_almost_full_i(afull),
    .tx_buffer_write_strobe_o(strobe), .tx_buffer_word_o(txw), .rx_buffer_empty_i(empty),
    .rx_buffer_word_i(rxw), .rx_buffer_pop_o(pop), .write_transfer_active_o(active),
    .verify_fail_o(fail));

  ptg_fifo_model u_ptg_fifo_model (.mclk_i(mclk), .reset_n_i(reset_n), .tx_stall_i(stall),
    .rx_hold_i(hold), .corrupt_i(corrupt), .wr_strobe_i(strobe), .wr_word_i(txw),
    .almost_full_o(afull), .pop_i(pop), .empty_o(empty), .rd_word_o(rxw));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [255:0] seen, input logic [255:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], ^(s & `PTG_LFSR_TAPS)};
  endfunction

  // Expected word n of a run; independent of the design's own logic
  function automatic logic [255:0] exp_word(input logic [2:0] s, input logic [47:0] a,
                                            input int n);
    logic [47:0] sa;
    logic [3:0] w;
    logic [31:0] l0, l1;
    logic [255:0] r;
    sa = a + 48'(n / 16);
    w = 4'(n % 16);
    r = 256'h0;
    l0 = {~sa[31:16], sa[15:0]};
    l1 = {sa[31:16], ~sa[15:0]};
    for (int i = 0; i < 4 * w; i++) begin
      l0 = step(l0);
      l1 = step(l1);
    end
    for (int k = 0; k < 8; k++) begin
      case (s)
        3'h0: r[32*k +: 32] = {sa[24:0], w, 3'(k)};
        3'h1: r[32*k +: 32] = ~{sa[24:0], w, 3'(k)};
        3'h3: r[32*k +: 32] = 32'hFFFFFFFF;
        3'h4: begin
          r[32*k +: 32] = k[0] ? l1 : l0;
          if (k[0]) l1 = step(l1);
          else l0 = step(l0);
        end
        default: r[32*k +: 32] = 32'h00000000;
      endcase
    end
    if (w == 4'h0) r[63:0] = {16'h0000, sa};
    return r;
  endfunction

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    req <= '0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge mclk);
    req <= '0;
    #1 d = rdata;
  endtask

  task automatic wait_idle();
    logic [31:0] st;
    for (int i = 0; i < 400; i++) begin
      reg_rd(`PTG_OFF_STATUS, st);
      if (st[1:0] === 2'b00) return;
    end
    err_total++;
    $display("wrong value at %0t: %s", $time, "operation never ended");
    test_done();
  endtask

  // One write of n words then a loopback read; bad corrupts the returned data
  task automatic run(input logic [2:0] s, input logic [31:0] n, input logic bad);
    logic [31:0] st;
    sel = s;
    nwr = 0;
    reg_wr(`PTG_OFF_PATSEL, {29'h0, s});
    reg_wr(`PTG_OFF_END, n);
    reg_wr(`PTG_OFF_ADDR_LO, base[31:0]);
    reg_wr(`PTG_OFF_ADDR_HI, {16'h0000, base[47:32]});
    reg_wr(`PTG_OFF_CTRL, 32'h00000001);
    reg_rd(`PTG_OFF_STATUS, st);
    chk(st[0], 1'b1, "write not active");
    chk(fail, 1'b0, "fail not cleared by start");
    // A second start while a long write runs must not restart it; a short one is over by then
    if (n > 32'h00000004) reg_wr(`PTG_OFF_CTRL, 32'h00000001);
    wait_idle();
    chk(nwr, n, "written word total");
    reg_rd(`PTG_OFF_COUNT, st);
    chk(st, n, "word counter");
    chk(active, 1'b0, "active after end");
    corrupt <= bad;
    reg_wr(`PTG_OFF_CTRL, 32'h00000002);
    wait_idle();
    corrupt <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(fail, bad, "verify flag");
    reg_rd(`PTG_OFF_STATUS, st);
    chk(st[2], bad, "status fail bit");
    $display("test pattern %0d length %0d done", s, n);
  endtask

  // ---------------------------------------------------------------
  // Monitors
  // ---------------------------------------------------------------
  // Irregular stalls on both buffers in the flow-control runs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    stall <= stall_en & (cyc % 5 < 2);
    hold <= stall_en & (cyc % 7 < 3);
  end

  // word contents, pause on afull, pop only with data
  always @(posedge mclk) begin
    af_d1 <= afull;
    af_d2 <= af_d1;
    if (reset_n && ce && strobe) begin
      chk(txw, exp_word(sel, base, nwr), "transmit word");
      nwr <= nwr + 1;
    end
    if (reset_n && af_d1 && af_d2) chk(strobe, 1'b0, "strobe while afull");
    if (reset_n && pop) chk(empty | active, 1'b0, "pop without data");
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] v;
    reset_n = 1'b0;
    ce = 1'b1;
    req = '0;
    corrupt = 1'b0;
    stall_en = 1'b0;
    sel = 3'h0;
    base = 48'h00000012FFFF;
    repeat (5) @(posedge mclk);
    chk({strobe, pop, active, fail}, 4'h0, "outputs in reset");
    reset_n <= 1'b1;
    // Every offset, the unmapped one too, reads zero after reset
    for (int a = 0; a < 32; a += 4) begin
      reg_rd(8'(a), v);
      chk(v, 32'h00000000, "reset register value");
    end
    reg_wr(8'h1C, 32'hFFFFFFFF);
    ce <= 1'b0;
    reg_wr(`PTG_OFF_PATSEL, 32'h00000003);
    ce <= 1'b1;
    reg_rd(`PTG_OFF_PATSEL, v);
    chk(v, 32'h00000000, "write taken while frozen");
    reg_rd(8'h1C, v);
    chk(v, 32'h00000000, "unmapped readback");
    $display("test reset and registers done");
    for (int s = 0; s < 6; s++) begin
      stall_en = (s >= 3);
      run(3'(s), 32'h00000012, 1'b0);
    end
    run(3'h4, 32'h00000011, 1'b1);
    stall_en = 1'b0;
    run(3'h0, 32'h00000001, 1'b0);
    test_done();
  end
endmodule
